// ---- common/arith_decode_pkg.sv ----
package arith_decode_pkg;

	// ****************************************************************
	// Opcode patterns and selectors
	// ****************************************************************
	localparam logic [7:0] ESCAPE_BYTE = 8'h0F;
	localparam logic [7:0] PRODUCT_2ND = 8'hAF;
	localparam logic [7:0] ASCII_ADD_OPC = 8'h37;
	localparam logic [7:0] ASCII_SUB_OPC = 8'h3F;
	localparam logic [7:0] DECIMAL_ADD_OPC = 8'h27;
	localparam logic [7:0] DECIMAL_SUB_OPC = 8'h2F;
	localparam logic [5:0] GRP_DIFF = 6'h0A;
	localparam logic [5:0] GRP_BORROW = 6'h06;
	localparam logic [5:0] GRP_CMP = 6'h0E;
	localparam logic [5:0] GRP_IMM = 6'h20;
	localparam logic [6:0] GRP_DIFF_ACC = 7'h16;
	localparam logic [6:0] GRP_BORROW_ACC = 7'h0E;
	localparam logic [6:0] GRP_CMP_ACC = 7'h1E;
	localparam logic [6:0] GRP_UNARY = 7'h7B;
	localparam logic [6:0] GRP_STEP = 7'h7F;
	localparam logic [4:0] GRP_MINUS_SHORT = 5'h09;
	localparam logic [5:0] GRP_PRODUCT_IMM = 6'h1A;
	localparam logic [2:0] SEL_DIFF = 3'h5;
	localparam logic [2:0] SEL_BORROW = 3'h3;
	localparam logic [2:0] SEL_CMP = 3'h7;
	localparam logic [2:0] SEL_MINUS = 3'h1;
	localparam logic [2:0] SEL_FLIP = 3'h3;
	localparam logic [2:0] SEL_UPROD = 3'h4;
	localparam logic [2:0] SEL_SPROD = 3'h5;
	localparam logic [1:0] MOD_REG = 2'h3;

	// ****************************************************************
	// Clock counts
	// ****************************************************************
	localparam logic [5:0] CLK_FOREIGN = 6'h01;
	localparam logic [5:0] CLK_REG = 6'h02;
	localparam logic [5:0] CLK_ADJUST = 6'h04;
	localparam logic [5:0] CLK_CMP_STORE = 6'h05;
	localparam logic [5:0] CLK_STORE = 6'h06;
	localparam logic [5:0] CLK_LOAD = 6'h07;
	localparam logic [5:0] CLK_MUL_BASE = 6'h09;
	localparam logic [5:0] CLK_MUL_MEM = 6'h03;
	localparam logic [5:0] MUL_EXTRA_BYTE = 6'h05;
	localparam logic [5:0] MUL_EXTRA_WORD = 6'h0D;
	localparam logic [5:0] MUL_EXTRA_DWORD = 6'h1D;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		op_foreign, op_difference, borrow_difference, minus_one, compare_op, sign_flip,
		ascii_add_adjust, ascii_subtract_adjust, decimal_add_adjust,
		decimal_subtract_adjust, unsigned_product, signed_product
	} op_kind_t;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} op_size_t;

	typedef struct packed {
		op_kind_t op;
		op_size_t size;
		logic mem;
		logic [5:0] clocks;
	} decode_result_t;

endpackage : arith_decode_pkg

// ---- core/arith_decode.sv ----
`timescale 1ns/1ps

module arith_decode
	import arith_decode_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic op32,
	input wire logic [4:0] mul_extra,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	output logic busy,
	output logic done,
	output decode_result_t result
);

	// ****************************************************************
	// Decode functions
	// ****************************************************************
	function automatic op_size_t size_of(input logic w, input logic wide);
		size_of = !w ? SZ_BYTE : (wide ? SZ_DWORD : SZ_WORD);
	endfunction : size_of

	function automatic logic need_modrm(input logic [7:0] opc, input logic esc);
		need_modrm = esc ? (opc == PRODUCT_2ND) :
			(opc[7:2] == GRP_DIFF) || (opc[7:2] == GRP_BORROW) ||
			(opc[7:2] == GRP_CMP) || (opc[7:2] == GRP_IMM) ||
			(opc[7:1] == GRP_STEP) || (opc[7:1] == GRP_UNARY) ||
			({opc[7:2], opc[0]} == {GRP_PRODUCT_IMM, 1'b1});
	endfunction : need_modrm

	// Full-size immediates follow the operand size; s=1 means one byte.
	function automatic logic [2:0] imm_len(input logic [7:0] opc, input logic esc,
		input logic wide);
		logic [2:0] full;
		full = wide ? 3'h4 : 3'h2;
		imm_len = 3'h0;
		if (esc)
			imm_len = 3'h0;
		else if (opc[7:2] == GRP_IMM)
			imm_len = (!opc[0] || opc[1]) ? 3'h1 : full;
		else if ((opc[7:1] == GRP_DIFF_ACC) || (opc[7:1] == GRP_BORROW_ACC) ||
			(opc[7:1] == GRP_CMP_ACC))
			imm_len = opc[0] ? full : 3'h1;
		else if ({opc[7:2], opc[0]} == {GRP_PRODUCT_IMM, 1'b1})
			imm_len = opc[1] ? 3'h1 : full;
	endfunction : imm_len

	// Early-out products: the multiplier's magnitude adds up to a size limit.
	function automatic logic [5:0] mul_clocks(input op_size_t sz, input logic mem,
		input logic [4:0] extra);
		logic [5:0] lim;
		logic [5:0] ext;
		lim = (sz == SZ_BYTE) ? MUL_EXTRA_BYTE :
			(sz == SZ_WORD) ? MUL_EXTRA_WORD : MUL_EXTRA_DWORD;
		ext = ({1'b0, extra} > lim) ? lim : {1'b0, extra};
		mul_clocks = CLK_MUL_BASE + ext + (mem ? CLK_MUL_MEM : 6'h00);
	endfunction : mul_clocks

	function automatic decode_result_t classify(input logic [7:0] opc, input logic esc,
		input logic [7:0] modrm, input logic wide, input logic [4:0] extra);
		decode_result_t r;
		logic mem;
		logic [2:0] sel;
		mem = modrm[7:6] != MOD_REG;
		sel = modrm[5:3];
		r = '{op: op_foreign, size: size_of(opc[0], wide), mem: 1'b0, clocks: CLK_FOREIGN};
		if (esc)
		begin
			if (opc == PRODUCT_2ND)
				r = '{signed_product, size_of(1'b1, wide), mem,
					mul_clocks(size_of(1'b1, wide), mem, extra)};
		end
		else if (opc[7:2] == GRP_DIFF)
			r = '{op_difference, r.size, mem,
				!mem ? CLK_REG : (opc[1] ? CLK_STORE : CLK_LOAD)};
		else if (opc[7:2] == GRP_BORROW)
			r = '{borrow_difference, r.size, mem,
				!mem ? CLK_REG : (opc[1] ? CLK_STORE : CLK_LOAD)};
		else if (opc[7:2] == GRP_CMP)
			r = '{compare_op, r.size, mem,
				!mem ? CLK_REG : (opc[1] ? CLK_STORE : CLK_CMP_STORE)};
		else if (opc[7:2] == GRP_IMM)
		begin
			if (sel == SEL_DIFF)
				r = '{op_difference, r.size, mem, mem ? CLK_LOAD : CLK_REG};
			else if (sel == SEL_BORROW)
				r = '{borrow_difference, r.size, mem, mem ? CLK_LOAD : CLK_REG};
			else if (sel == SEL_CMP)
				r = '{compare_op, r.size, mem, mem ? CLK_CMP_STORE : CLK_REG};
		end
		else if (opc[7:1] == GRP_STEP)
		begin
			if (sel == SEL_MINUS)
				r = '{minus_one, r.size, mem, mem ? CLK_STORE : CLK_REG};
		end
		else if (opc[7:1] == GRP_UNARY)
		begin
			if (sel == SEL_FLIP)
				r = '{sign_flip, r.size, mem, mem ? CLK_STORE : CLK_REG};
			else if (sel == SEL_UPROD)
				r = '{unsigned_product, r.size, mem, mul_clocks(r.size, mem, extra)};
			else if (sel == SEL_SPROD)
				r = '{signed_product, r.size, mem, mul_clocks(r.size, mem, extra)};
		end
		else if ({opc[7:2], opc[0]} == {GRP_PRODUCT_IMM, 1'b1})
			r = '{signed_product, size_of(1'b1, wide), mem,
				mul_clocks(size_of(1'b1, wide), mem, extra)};
		else if (opc[7:1] == GRP_DIFF_ACC)
			r = '{op_difference, r.size, 1'b0, CLK_REG};
		else if (opc[7:1] == GRP_BORROW_ACC)
			r = '{borrow_difference, r.size, 1'b0, CLK_REG};
		else if (opc[7:1] == GRP_CMP_ACC)
			r = '{compare_op, r.size, 1'b0, CLK_REG};
		else if (opc[7:3] == GRP_MINUS_SHORT)
			r = '{minus_one, size_of(1'b1, wide), 1'b0, CLK_REG};
		else if (opc == ASCII_ADD_OPC)
			r = '{ascii_add_adjust, SZ_BYTE, 1'b0, CLK_ADJUST};
		else if (opc == ASCII_SUB_OPC)
			r = '{ascii_subtract_adjust, SZ_BYTE, 1'b0, CLK_ADJUST};
		else if (opc == DECIMAL_ADD_OPC)
			r = '{decimal_add_adjust, SZ_BYTE, 1'b0, CLK_ADJUST};
		else if (opc == DECIMAL_SUB_OPC)
			r = '{decimal_subtract_adjust, SZ_BYTE, 1'b0, CLK_ADJUST};
		classify = r;
	endfunction : classify

	// ****************************************************************
	// Byte collection
	// ****************************************************************
	typedef enum logic [2:0] {ST_OPCODE, ST_ESCAPE, ST_MODRM, ST_IMM, ST_EXEC} state_t;

	state_t state;
	state_t next_state;
	logic [7:0] opc;
	logic esc;
	logic [7:0] modrm;
	logic [2:0] imm_left;
	logic [5:0] count;

	wire logic take = byte_valid && byte_ready;
	wire logic head = (state == ST_OPCODE) || (state == ST_ESCAPE);
	wire logic [7:0] cur_opc = head ? byte_data : opc;
	wire logic cur_esc = (state == ST_ESCAPE) || ((state != ST_OPCODE) && esc);
	wire logic [7:0] cur_modrm = (state == ST_MODRM) ? byte_data : modrm;
	wire logic [2:0] cur_imm = imm_len(cur_opc, cur_esc, op32);
	wire decode_result_t info = classify(cur_opc, cur_esc, cur_modrm, op32, mul_extra);
	wire logic enter_exec = (next_state == ST_EXEC) && (state != ST_EXEC);

	assign byte_ready = state != ST_EXEC;
	assign busy = state == ST_EXEC;
	assign done = (state == ST_EXEC) && (count == 6'h00);

	always_comb
	begin
		next_state = state;
		case (state)
			ST_OPCODE, ST_ESCAPE:
				if (byte_valid)
				begin
					if ((state == ST_OPCODE) && (byte_data == ESCAPE_BYTE))
						next_state = ST_ESCAPE;
					else if (need_modrm(cur_opc, cur_esc))
						next_state = ST_MODRM;
					else if (cur_imm != 3'h0)
						next_state = ST_IMM;
					else
						next_state = ST_EXEC;
				end
			ST_MODRM:
				if (byte_valid)
					next_state = (cur_imm != 3'h0) ? ST_IMM : ST_EXEC;
			ST_IMM:
				if (byte_valid && (imm_left == 3'h1))
					next_state = ST_EXEC;
			default:
				if (count == 6'h00)
					next_state = ST_OPCODE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_OPCODE;
			opc <= 8'h00;
			esc <= 1'b0;
			modrm <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (take && head)
			begin
				opc <= byte_data;
				esc <= state == ST_ESCAPE;
			end
			if (take && (state == ST_MODRM))
				modrm <= byte_data;
		end
	end

	// ****************************************************************
	// Execution timing
	// ****************************************************************
	// The result is frozen at entry so mul_extra may change during execution.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			imm_left <= 3'h0;
			count <= 6'h00;
			result <= '{op_foreign, SZ_BYTE, 1'b0, 6'h00};
		end
		else
		begin
			if ((next_state == ST_IMM) && (state != ST_IMM))
				imm_left <= cur_imm;
			else if (take && (state == ST_IMM))
				imm_left <= imm_left - 3'h1;
			if (enter_exec)
			begin
				count <= info.clocks - 6'h01;
				result <= info;
			end
			else if (busy && (count != 6'h00))
				count <= count - 6'h01;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [5:0] exec_cycles;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			exec_cycles <= 6'h00;
		else
			exec_cycles <= busy ? exec_cycles + 6'h01 : 6'h00;
	end

	wire logic mem_form = cur_modrm[7:6] != MOD_REG;

	sequence s_finish_after_seven;
		!done [*6] ##1 done;
	endsequence

	sequence s_finish_after_six;
		!done [*5] ##1 done;
	endsequence

	a_sub_load_seven: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && !cur_esc && (cur_opc[7:1] == 7'h14) && mem_form |=> s_finish_after_seven)
		else $error("difference load did not finish in seven clocks");

	a_sub_store_six: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && !cur_esc && (cur_opc[7:1] == 7'h15) && mem_form |=> s_finish_after_six)
		else $error("difference store did not finish in six clocks");

	a_imm_borrow_time: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && !cur_esc && (cur_opc[7:2] == GRP_IMM) && (cur_modrm[5:3] == SEL_BORROW)
		|=> (result.op == borrow_difference) && (result.clocks == (mem_form ? 6'h07 : 6'h02)))
		else $error("immediate borrow difference timed wrongly");

	a_cmp_store_five: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && !cur_esc && (cur_opc[7:1] == 7'h1C) && mem_form
		|=> !done [*4] ##1 done)
		else $error("compare memory with register not five clocks");

	a_adjust_four: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && (state == ST_OPCODE) && ((byte_data == ASCII_ADD_OPC) ||
		(byte_data == DECIMAL_SUB_OPC)) |=> busy ##3 done)
		else $error("adjust did not take four clocks");

	a_done_length: assert property (@(posedge ref_clk) disable iff (rst)
		done |-> (exec_cycles + 6'h01 == result.clocks) ##1 !busy)
		else $error("execution length differs from scheduled count");

	a_product_range: assert property (@(posedge ref_clk) disable iff (rst)
		done && ((result.op == unsigned_product) || (result.op == signed_product))
		|-> (exec_cycles >= (result.mem ? 6'h0B : 6'h08)) &&
		(exec_cycles <= (result.mem ? 6'h03 : 6'h00) + (result.size == SZ_BYTE ? 6'h0D :
		(result.size == SZ_WORD ? 6'h15 : 6'h25))))
		else $error("product time outside its range");

	a_flip_decode: assert property (@(posedge ref_clk) disable iff (rst)
		enter_exec && !cur_esc && (cur_opc[7:1] == GRP_UNARY) && (cur_modrm[5:3] == SEL_FLIP)
		|=> (result.op == sign_flip) && (result.clocks == (result.mem ? 6'h06 : 6'h02)))
		else $error("sign flip decoded wrongly");

	a_no_take_busy: assert property (@(posedge ref_clk) disable iff (rst)
		busy |-> !byte_ready ##1 ($stable(opc) && $stable(modrm)))
		else $error("bytes taken while executing");

endmodule : arith_decode

// ---- bench/fetch_model.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Instruction byte source standing in for the fetch and prefetch logic
// ****************************************************************
module fetch_model
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	logic [7:0] pending[$];
	logic gap;

	task automatic push(input logic [7:0] b);
		pending.push_back(b);
	endtask : push

	// A byte that was offered stays put until it is taken.
	// When idle the data lines toggle so a stale byte can never pass for a fresh one.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
			gap <= 1'b0;
		end
		else if (byte_valid && !byte_ready)
			gap <= 1'b0;
		else if (pending.size() != 0 && !(slow && !gap))
		begin
			byte_valid <= 1'b1;
			byte_data <= pending.pop_front();
			gap <= 1'b0;
		end
		else
		begin
			byte_valid <= 1'b0;
			byte_data <= ~byte_data;
			gap <= 1'b1;
		end
	end
endmodule : fetch_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
	import arith_decode_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic op32 = 1'b0;
	logic [4:0] mul_extra = 5'h00;
	logic slow = 1'b0;
	logic byte_valid;
	logic [7:0] byte_data;
	logic byte_ready;
	logic busy;
	logic done;
	decode_result_t result;
	int n_fail = 0;
	int comparisons = 0;

	always #12.5 ref_clk = ~ref_clk;

	fetch_model fetch (.ref_clk(ref_clk), .rst(rst), .slow(slow), .byte_ready(byte_ready),
		.byte_valid(byte_valid), .byte_data(byte_data));
	arith_decode dut (.ref_clk(ref_clk), .rst(rst), .op32(op32), .mul_extra(mul_extra),
		.byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
		.busy(busy), .done(done), .result(result));

	// ****************************************************************
	// Compare and transfer helpers
	// ****************************************************************
	task automatic chk_res(input decode_result_t got, input decode_result_t exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t result %h expected %h", $time, got, exp);
		end
	endtask : chk_res

	task automatic chk_cnt(input int got, input int exp);
		comparisons++;
		if (got != exp)
		begin
			n_fail++;
			$display("BAD t=%0t busy cycles %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic setup(input logic wide, input logic [4:0] extra);
		@(posedge ref_clk);
		op32 <= wide;
		mul_extra <= extra;
	endtask : setup

	// Counts only the cycles in which the block is busy and refuses bytes.
	task automatic wait_op(input decode_result_t exp);
		int n;
		int k;
		n = 0;
		for (k = 0; k < 200; k++)
		begin
			@(posedge ref_clk);
			#1;
			if (busy === 1'b1 && byte_ready === 1'b0)
				n++;
			if (done === 1'b1)
				break;
		end
		if (k == 200)
		begin
			n_fail++;
			$display("BAD t=%0t no completion", $time);
		end
		chk_res(result, exp);
		chk_cnt(n, exp.clocks);
	endtask : wait_op

	task automatic do_op(input logic [7:0] b[$], input op_kind_t op, input op_size_t sz,
		input logic mem, input logic [5:0] clk);
		foreach (b[i])
			fetch.push(b[i]);
		wait_op('{op, sz, mem, clk});
	endtask : do_op

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_difference;
		setup(1'b1, 5'h00);
		slow <= 1'b1;
		do_op('{8'h28, 8'h05}, op_difference, SZ_BYTE, 1'b1, 6'd7);
		do_op('{8'h2B, 8'h05}, op_difference, SZ_DWORD, 1'b1, 6'd6);
		do_op('{8'h83, 8'hE8, 8'h05}, op_difference, SZ_DWORD, 1'b0, 6'd2);
		do_op('{8'h81, 8'h2E, 8'h01, 8'h02, 8'h03, 8'h04}, op_difference, SZ_DWORD, 1'b1, 6'd7);
		slow <= 1'b0;
		do_op('{8'h2C, 8'h12}, op_difference, SZ_BYTE, 1'b0, 6'd2);
	endtask : t_difference

	task automatic t_borrow;
		setup(1'b0, 5'h00);
		do_op('{8'h1A, 8'hC1}, borrow_difference, SZ_BYTE, 1'b0, 6'd2);
		do_op('{8'h19, 8'h06}, borrow_difference, SZ_WORD, 1'b1, 6'd7);
		do_op('{8'h1B, 8'h06}, borrow_difference, SZ_WORD, 1'b1, 6'd6);
		do_op('{8'h80, 8'h1E, 8'h7F}, borrow_difference, SZ_BYTE, 1'b1, 6'd7);
		do_op('{8'h1D, 8'h01, 8'h02}, borrow_difference, SZ_WORD, 1'b0, 6'd2);
	endtask : t_borrow

	task automatic t_minus_flip;
		setup(1'b1, 5'h00);
		do_op('{8'hFE, 8'hC8}, minus_one, SZ_BYTE, 1'b0, 6'd2);
		do_op('{8'hFF, 8'h08}, minus_one, SZ_DWORD, 1'b1, 6'd6);
		do_op('{8'h48}, minus_one, SZ_DWORD, 1'b0, 6'd2);
		do_op('{8'hF6, 8'hD8}, sign_flip, SZ_BYTE, 1'b0, 6'd2);
		do_op('{8'hF7, 8'h18}, sign_flip, SZ_DWORD, 1'b1, 6'd6);
	endtask : t_minus_flip

	task automatic t_compare;
		setup(1'b0, 5'h00);
		do_op('{8'h38, 8'hC0}, compare_op, SZ_BYTE, 1'b0, 6'd2);
		do_op('{8'h38, 8'h00}, compare_op, SZ_BYTE, 1'b1, 6'd5);
		do_op('{8'h3B, 8'h00}, compare_op, SZ_WORD, 1'b1, 6'd6);
		do_op('{8'h83, 8'hF8, 8'h01}, compare_op, SZ_WORD, 1'b0, 6'd2);
		do_op('{8'h83, 8'h38, 8'h01}, compare_op, SZ_WORD, 1'b1, 6'd5);
		do_op('{8'h3C, 8'h01}, compare_op, SZ_BYTE, 1'b0, 6'd2);
	endtask : t_compare

	// All four adjust opcodes queued at once, so each waits while the previous one runs.
	task automatic t_adjust;
		fetch.push(ASCII_ADD_OPC);
		fetch.push(ASCII_SUB_OPC);
		fetch.push(DECIMAL_ADD_OPC);
		fetch.push(DECIMAL_SUB_OPC);
		wait_op('{ascii_add_adjust, SZ_BYTE, 1'b0, 6'd4});
		wait_op('{ascii_subtract_adjust, SZ_BYTE, 1'b0, 6'd4});
		wait_op('{decimal_add_adjust, SZ_BYTE, 1'b0, 6'd4});
		wait_op('{decimal_subtract_adjust, SZ_BYTE, 1'b0, 6'd4});
	endtask : t_adjust

	// Early-out counts at the top of each size's range, the word memory minimum and two mid-range cases, with clamping of an oversized request.
	task automatic t_product;
		setup(1'b0, 5'h1F);
		do_op('{8'hF6, 8'hE0}, unsigned_product, SZ_BYTE, 1'b0, 6'd14);
		do_op('{8'hF7, 8'hE8}, signed_product, SZ_WORD, 1'b0, 6'd22);
		setup(1'b0, 5'h00);
		do_op('{8'hF7, 8'h20}, unsigned_product, SZ_WORD, 1'b1, 6'd12);
		setup(1'b1, 5'h1F);
		do_op('{8'hF7, 8'h20}, unsigned_product, SZ_DWORD, 1'b1, 6'd41);
		setup(1'b1, 5'h02);
		do_op('{8'hF6, 8'h28}, signed_product, SZ_BYTE, 1'b1, 6'd14);
		setup(1'b0, 5'h0D);
		do_op('{ESCAPE_BYTE, PRODUCT_2ND, 8'hC0}, signed_product, SZ_WORD, 1'b0, 6'd22);
		setup(1'b1, 5'h1F);
		do_op('{ESCAPE_BYTE, PRODUCT_2ND, 8'h00}, signed_product, SZ_DWORD, 1'b1, 6'd41);
		setup(1'b0, 5'h04);
		do_op('{8'h6B, 8'hC0, 8'h05}, signed_product, SZ_WORD, 1'b0, 6'd13);
		setup(1'b0, 5'h1F);
		do_op('{8'h69, 8'h00, 8'h01, 8'h02}, signed_product, SZ_WORD, 1'b1, 6'd25);
	endtask : t_product

	// Opcodes outside the group still consume their trailing bytes and finish in one clock.
	task automatic t_foreign;
		setup(1'b0, 5'h00);
		do_op('{ESCAPE_BYTE, 8'h06}, op_foreign, SZ_BYTE, 1'b0, 6'h01);
		do_op('{8'h81, 8'hC0, 8'h01, 8'h02}, op_foreign, SZ_WORD, 1'b0, 6'h01);
		do_op('{8'hFE, 8'hC0}, op_foreign, SZ_BYTE, 1'b0, 6'h01);
		do_op('{8'h4A}, minus_one, SZ_WORD, 1'b0, 6'h02);
	endtask : t_foreign

	// ****************************************************************
	// Sequence, watchdog and verdict
	// ****************************************************************
	task automatic end_sim;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk_res(result, '{op_foreign, SZ_BYTE, 1'b0, 6'd0});
		chk_cnt(int'(byte_ready === 1'b1 && busy === 1'b0 && done === 1'b0), 1);
		t_difference();
		t_borrow();
		t_minus_flip();
		t_compare();
		t_adjust();
		t_product();
		t_foreign();
		end_sim();
	end

	initial
	begin
		#(25 * 5000);
		n_fail++;
		$display("BAD t=%0t watchdog expired", $time);
		end_sim();
	end
endmodule : tb_top
